// ---- hdl/irq_ctl.sv ----
/*
 * Interrupt controller of a three-axis motion sensor: latched event flags,
 * enable mask, pin mapping onto two push-pull outputs and polarity control.
 * Assumes the register port, the detectors and the FIFO logic all run on clk;
 * the serial bus engine drives the register port with one-cycle strobes.
 */
`timescale 1ns/10ps

// What this block does
// - Two interrupt outputs exist and both are always driven, never released.
// - Outputs are active high after reset and active low when the invert bit is set.
// - A function reaches an output only while its enable bit is set.
// - The pin-select bit of each enabled function picks the first or second output.
// - All functions run at once and functions on the same pin are ORed together.
// - Event flags stay latched until their clearing read, not just while the cause lasts.
// - Data-related flags clear on data register reads only once their cause is gone.
// - Reading the source register returns the flags and clears the other flags.
// - The new-sample flag sets when fresh data exists and drops when none is unread.
// - The FIFO level flag sets on the threshold match and clears when reads go below it.
// - The overflow flag sets on lost data and clears when the stored data is read.
module irq_ctl (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // register port from the serial bus engine
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // event pulses from the detectors
    input wire logic evt_single_tap,
    input wire logic evt_double_tap,
    input wire logic evt_activity,
    input wire logic evt_inactivity,
    input wire logic evt_free_fall,
    input wire logic evt_overrun,
    // levels from the sample and FIFO logic
    input wire logic new_data_avail,
    input wire logic fifo_at_level,
    // outputs
    output logic irq_out_first,
    output logic irq_out_second,
    output logic [7:0] format_bits
);
    flag_if fl ();

    logic [7:0] enable_r;
    logic [7:0] enable_nxt;
    logic [7:0] map_r;
    logic [7:0] map_nxt;
    logic [7:0] format_r;
    logic [7:0] format_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic pin_first_r;
    logic pin_first_nxt;
    logic pin_second_r;
    logic pin_second_nxt;
    logic src_rd;
    logic data_rd;
    logic [7:0] route_first;
    logic [7:0] route_second;

    // decode of reads that clear flags
    assign src_rd = reg_rd && (reg_addr == irq_pkg::ADDR_SOURCE);
    assign data_rd = reg_rd && (reg_addr >= irq_pkg::ADDR_DATA_FIRST)
                     && (reg_addr <= irq_pkg::ADDR_DATA_LAST);

    // set and clear requests; data flags re-arm while their cause is present,
    // so a read that leaves data unread cannot drop them
    always_comb begin
        fl.set = 8'h00;
        fl.clr = 8'h00;
        fl.set[irq_pkg::BIT_DRDY] = new_data_avail;
        fl.clr[irq_pkg::BIT_DRDY] = data_rd && !new_data_avail;
        fl.set[irq_pkg::BIT_WMARK] = fifo_at_level;
        fl.clr[irq_pkg::BIT_WMARK] = data_rd && !fifo_at_level;
        fl.set[irq_pkg::BIT_OVRUN] = evt_overrun;
        fl.clr[irq_pkg::BIT_OVRUN] = data_rd;
        fl.set[irq_pkg::BIT_STAP] = evt_single_tap;
        fl.set[irq_pkg::BIT_DTAP] = evt_double_tap;
        fl.set[irq_pkg::BIT_ACT] = evt_activity;
        fl.set[irq_pkg::BIT_INACT] = evt_inactivity;
        fl.set[irq_pkg::BIT_FFALL] = evt_free_fall;
        fl.clr[irq_pkg::BIT_STAP] = src_rd;
        fl.clr[irq_pkg::BIT_DTAP] = src_rd;
        fl.clr[irq_pkg::BIT_ACT] = src_rd;
        fl.clr[irq_pkg::BIT_INACT] = src_rd;
        fl.clr[irq_pkg::BIT_FFALL] = src_rd;
    end

    irq_flag_bank u_bank (
        .clk(clk),
        .srst(srst),
        .fb(fl.bank)
    );

    // configuration registers written from the register port
    always_comb begin
        enable_nxt = enable_r;
        map_nxt = map_r;
        format_nxt = format_r;
        if (reg_wr) begin
            case (reg_addr)
                irq_pkg::ADDR_ENABLE: enable_nxt = reg_wdata;
                irq_pkg::ADDR_MAP: map_nxt = reg_wdata;
                irq_pkg::ADDR_FORMAT: format_nxt = reg_wdata;
                default: ;
            endcase
        end
    end

    // read data is registered; the source read returns flags before they clear
    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_rd) begin
            case (reg_addr)
                irq_pkg::ADDR_ENABLE: rdata_nxt = enable_r;
                irq_pkg::ADDR_MAP: rdata_nxt = map_r;
                irq_pkg::ADDR_SOURCE: rdata_nxt = fl.flags;
                irq_pkg::ADDR_FORMAT: rdata_nxt = format_r;
                default: rdata_nxt = irq_pkg::ZERO_BYTE; // other offsets live elsewhere
            endcase
        end
    end

    // pin routing; each function feeds the first or second OR per its pin-select bit
    always_comb begin
        route_first = fl.flags & enable_r & ~map_r;
        route_second = fl.flags & enable_r & map_r;
        pin_first_nxt = (|route_first) ^ format_r[irq_pkg::BIT_INVERT];
        pin_second_nxt = (|route_second) ^ format_r[irq_pkg::BIT_INVERT];
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            enable_r <= irq_pkg::RST_ENABLE;
            map_r <= irq_pkg::RST_MAP;
            format_r <= irq_pkg::RST_FORMAT;
            rdata_r <= irq_pkg::RST_RDATA;
            pin_first_r <= 1'b0;
            pin_second_r <= 1'b0;
        end else begin
            enable_r <= enable_nxt;
            map_r <= map_nxt;
            format_r <= format_nxt;
            rdata_r <= rdata_nxt;
            pin_first_r <= pin_first_nxt;
            pin_second_r <= pin_second_nxt;
        end
    end

    // both pins are push-pull: always driven from a flop
    assign irq_out_first = pin_first_r;
    assign irq_out_second = pin_second_r;
    assign reg_rdata = rdata_r;
    assign format_bits = format_r;

    // a routed active high function shows as a high pin next cycle
    AST_FIRST_ACTIVE: assert property (@(posedge clk) disable iff (srst)
        ((|(fl.flags & enable_r & ~map_r)) && !format_r[irq_pkg::BIT_INVERT])
        |=> irq_out_first)
        else $error("first pin not asserted high for routed flag");

    // inverted polarity drives the second pin low when routed
    AST_SECOND_INVERT: assert property (@(posedge clk) disable iff (srst)
        ((|(fl.flags & enable_r & map_r)) && format_r[irq_pkg::BIT_INVERT])
        |=> !irq_out_second)
        else $error("second pin not asserted low under inversion");

    // a masked flag never reaches a pin
    AST_MASK_GATES: assert property (@(posedge clk) disable iff (srst)
        ((fl.flags & enable_r) == 8'h00)
        |=> (irq_out_first == $past(format_r[irq_pkg::BIT_INVERT]))
            && (irq_out_second == $past(format_r[irq_pkg::BIT_INVERT])))
        else $error("pin active with all flags masked");

    // a function mapped to the second pin leaves the first idle
    AST_MAP_SELECT: assert property (@(posedge clk) disable iff (srst)
        (((fl.flags & enable_r & ~map_r) == 8'h00) && ((fl.flags & enable_r & map_r) != 8'h00))
        |=> (irq_out_first != irq_out_second))
        else $error("pin selection not honoured");

    // source read clears single-tap and activity flags unless re-set
    AST_SRC_CLEAR: assert property (@(posedge clk) disable iff (srst)
        (src_rd && !evt_single_tap && !evt_activity)
        |=> (!fl.flags[irq_pkg::BIT_STAP] && !fl.flags[irq_pkg::BIT_ACT]))
        else $error("source read did not clear flags");

    // source read returns the flags as they stood
    AST_SRC_DATA: assert property (@(posedge clk) disable iff (srst)
        src_rd |=> (reg_rdata == $past(fl.flags)))
        else $error("source read data wrong");

    // an event in the clearing cycle survives
    AST_SET_WINS: assert property (@(posedge clk) disable iff (srst)
        (src_rd && evt_free_fall) |=> fl.flags[irq_pkg::BIT_FFALL] [*2])
        else $error("event lost against clear");

    // new-sample flag stays while no data read happens
    AST_DRDY_HOLD: assert property (@(posedge clk) disable iff (srst)
        (fl.flags[irq_pkg::BIT_DRDY] && !data_rd) |=> fl.flags[irq_pkg::BIT_DRDY])
        else $error("new-sample flag dropped without a data read");

    // new-sample flag drops once a data read leaves nothing unread
    AST_DRDY_DROP: assert property (@(posedge clk) disable iff (srst)
        (data_rd && !new_data_avail) |=> !fl.flags[irq_pkg::BIT_DRDY])
        else $error("new-sample flag kept with no unread data");

    // level flag clears when reads bring the count under the threshold
    AST_WMARK_CLEAR: assert property (@(posedge clk) disable iff (srst)
        (data_rd && !fifo_at_level) |=> !fl.flags[irq_pkg::BIT_WMARK])
        else $error("level flag not cleared");

    // overflow flag clears on a data read and sets on an overrun
    AST_OVRUN: assert property (@(posedge clk) disable iff (srst)
        (evt_overrun |=> fl.flags[irq_pkg::BIT_OVRUN])
        and ((data_rd && !evt_overrun) |=> !fl.flags[irq_pkg::BIT_OVRUN]))
        else $error("overflow flag wrong");

    // several functions on the second pin: the shared pin stays active
    AST_SHARED_PIN: assert property (@(posedge clk) disable iff (srst)
        (($countones(fl.flags & enable_r & map_r) > 1) && !format_r[irq_pkg::BIT_INVERT])
        |=> irq_out_second)
        else $error("shared pin missed a function");
endmodule

// ---- common/irq_pkg.sv ----
/*
 * Constants for the motion sensor interrupt logic: register offsets, flag bit
 * positions, reset values and field positions.
 * Assumes a byte-wide register port with byte offsets as seen by the host.
 */
package irq_pkg;
    // register offsets
    localparam logic [7:0] ADDR_ENABLE = 8'h2e;
    localparam logic [7:0] ADDR_MAP = 8'h2f;
    localparam logic [7:0] ADDR_SOURCE = 8'h30;
    localparam logic [7:0] ADDR_FORMAT = 8'h31;
    localparam logic [7:0] ADDR_DATA_FIRST = 8'h32;
    localparam logic [7:0] ADDR_DATA_LAST = 8'h37;

    // number of interrupt functions, one bit each in the enable, pin-select and source registers
    localparam int NUM_FUNCS = 8;

    // flag bit positions, shared by enable, pin-select and source registers
    localparam int BIT_DRDY = 7;
    localparam int BIT_STAP = 6;
    localparam int BIT_DTAP = 5;
    localparam int BIT_ACT = 4;
    localparam int BIT_INACT = 3;
    localparam int BIT_FFALL = 2;
    localparam int BIT_WMARK = 1;
    localparam int BIT_OVRUN = 0;

    // polarity-invert bit in the output-format register
    localparam int BIT_INVERT = 5;

    // reset values
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_MAP = 8'h00;
    localparam logic [7:0] RST_FORMAT = 8'h00;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_RDATA = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
endpackage

// ---- common/flag_if.sv ----
/*
 * Carrier between the interrupt controller and its flag bank: per-function
 * set and clear requests going in, latched flags coming out.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface flag_if;
    logic [7:0] set;
    logic [7:0] clr;
    logic [7:0] flags;

    modport bank (input set, input clr, output flags);
    modport ctl (output set, output clr, input flags);
endinterface

// ---- hdl/irq_flag_bank.sv ----
/*
 * Bank of sticky event flags, one per interrupt function.
 * Assumes set and clear requests are synchronous to clk; set wins over clear.
 */
`timescale 1ns/10ps
module irq_flag_bank (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // requests and latched flags
    flag_if.bank fb
);
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;

    // per-bit latch: an event in the clearing cycle is kept
    genvar i;
    generate
        for (i = 0; i < irq_pkg::NUM_FUNCS; i++) begin : g_flag
            always_comb begin
                flags_nxt[i] = fb.set[i] | (flags_r[i] & ~fb.clr[i]);
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (srst) begin
            flags_r <= irq_pkg::RST_FLAGS;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign fb.flags = flags_r;

    // a flag with no clear request must stay up
    AST_FLAG_HOLDS: assert property (@(posedge clk) disable iff (srst)
        (flags_r != 8'h00) |=> ((($past(flags_r) & ~$past(fb.clr)) & ~flags_r) == 8'h00))
        else $error("latched flag lost without a clear");
endmodule

// ---- verif/host_model.sv ----
/*
 * Host side of the interrupt block: a register master issuing one-cycle
 * read and write strobes; the bench itself watches the two interrupt pins.
 * Assumes the same-clock byte port with one-cycle read latency.
 */
`timescale 1ns/10ps
module host_model (
    // clock
    input wire logic clk,
    // register port
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    // idle values at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end

    // write strobe; address and data inverted afterwards so stale values never help
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    // read strobe; data taken once the registered answer has settled
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(negedge clk);
        d = reg_rdata;
    endtask
endmodule

// ---- verif/test_motion_sensor_irq_logic.sv ----
/*
 * Self-checking bench for the interrupt controller: latching, masking,
 * pin routing, polarity and both kinds of clearing read.
 * Assumes irq_pkg constants and the host model for register traffic.
 */
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module test_motion_sensor_irq_logic;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] evt = 8'h00;
    logic new_data = 1'b0;
    logic fifo_lvl = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, format_bits, v;
    logic reg_wr, reg_rd, pin1, pin2;
    int error_cnt = 0;
    int check_count = 0;

    // 10 MHz clock
    always #50 clk = ~clk;

    host_model u_host_model (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    irq_ctl u_irq_ctl (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .evt_single_tap(evt[6]), .evt_double_tap(evt[5]), .evt_activity(evt[4]),
        .evt_inactivity(evt[3]), .evt_free_fall(evt[2]), .evt_overrun(evt[0]),
        .new_data_avail(new_data), .fifo_at_level(fifo_lvl),
        .irq_out_first(pin1), .irq_out_second(pin2), .format_bits(format_bits));

    // pins settle two edges after a flag or register change
    task automatic settle();
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask

    // one-cycle event pulse on the bits of m, then wait for the pins
    task automatic pulse(input logic [7:0] m);
        @(posedge clk);
        evt <= m;
        @(posedge clk);
        evt <= 8'h00;
        @(posedge clk);
        @(negedge clk);
    endtask

    task automatic pins(input logic f, input logic s);
        `CHK("irq_out_first", f, pin1)
        `CHK("irq_out_second", s, pin2)
    endtask

    task automatic t_reset();
        logic [7:0] a [5];
        a = '{irq_pkg::ADDR_ENABLE, irq_pkg::ADDR_MAP, irq_pkg::ADDR_FORMAT,
              irq_pkg::ADDR_SOURCE, 8'h10};
        for (int i = 0; i < 5; i++) begin
            u_host_model.rd(a[i], v);
            `CHK("reset value", 8'h00, v)
        end
        pins(1'b0, 1'b0);
        $display("test reset done");
    endtask

    task automatic t_route();
        u_host_model.wr(irq_pkg::ADDR_MAP, 8'h0c);
        u_host_model.wr(irq_pkg::ADDR_ENABLE, 8'h1c);
        u_host_model.rd(irq_pkg::ADDR_MAP, v);
        `CHK("pin select readback", 8'h0c, v)
        u_host_model.rd(irq_pkg::ADDR_ENABLE, v);
        `CHK("enable readback", 8'h1c, v)
        pulse(8'h10);
        pins(1'b1, 1'b0);
        repeat (5) @(posedge clk);
        @(negedge clk);
        pins(1'b1, 1'b0);
        pulse(8'h0c);
        pins(1'b1, 1'b1);
        u_host_model.rd(irq_pkg::ADDR_SOURCE, v);
        `CHK("source", 8'h1c, v)
        settle();
        pins(1'b0, 1'b0);
        pulse(8'h60);
        pins(1'b0, 1'b0);
        u_host_model.rd(irq_pkg::ADDR_SOURCE, v);
        `CHK("masked source", 8'h60, v)
        u_host_model.rd(irq_pkg::ADDR_SOURCE, v);
        `CHK("source cleared", 8'h00, v)
        $display("test route done");
    endtask

    task automatic t_invert();
        u_host_model.wr(irq_pkg::ADDR_ENABLE, 8'h00);
        u_host_model.wr(irq_pkg::ADDR_MAP, 8'h00);
        u_host_model.wr(irq_pkg::ADDR_FORMAT, 8'h20);
        settle();
        pins(1'b1, 1'b1);
        `CHK("format_bits", 8'h20, format_bits)
        u_host_model.wr(irq_pkg::ADDR_ENABLE, 8'h04);
        pulse(8'h04);
        pins(1'b0, 1'b1);
        u_host_model.rd(irq_pkg::ADDR_SOURCE, v);
        settle();
        pins(1'b1, 1'b1);
        u_host_model.wr(irq_pkg::ADDR_FORMAT, 8'h00);
        $display("test invert done");
    endtask

    // free-fall event lands on the very edge that samples a source read
    task automatic t_collide();
        u_host_model.wr(irq_pkg::ADDR_ENABLE, 8'h04);
        fork
            u_host_model.rd(irq_pkg::ADDR_SOURCE, v);
            begin
                @(posedge clk);
                evt <= 8'h04;
                @(posedge clk);
                evt <= 8'h00;
            end
        join
        `CHK("collide source", 8'h00, v)
        settle();
        pins(1'b1, 1'b0);
        u_host_model.rd(irq_pkg::ADDR_SOURCE, v);
        `CHK("set wins source", 8'h04, v)
        settle();
        pins(1'b0, 1'b0);
        $display("test collide done");
    endtask

    task automatic t_data();
        u_host_model.wr(irq_pkg::ADDR_ENABLE, 8'h83);
        @(posedge clk) new_data <= 1'b1;
        settle();
        pins(1'b1, 1'b0);
        u_host_model.rd(8'h32, v);
        settle();
        pins(1'b1, 1'b0);
        @(posedge clk) new_data <= 1'b0;
        u_host_model.rd(8'h33, v);
        settle();
        pins(1'b0, 1'b0);
        pulse(8'h01);
        u_host_model.rd(irq_pkg::ADDR_SOURCE, v);
        `CHK("overrun source", 8'h01, v)
        settle();
        pins(1'b1, 1'b0);
        u_host_model.rd(8'h37, v);
        settle();
        pins(1'b0, 1'b0);
        @(posedge clk) fifo_lvl <= 1'b1;
        @(posedge clk) fifo_lvl <= 1'b0;
        settle();
        pins(1'b1, 1'b0);
        u_host_model.rd(8'h35, v);
        settle();
        pins(1'b0, 1'b0);
        $display("test data done");
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // main sequence after ten cycles of reset
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_route();
        t_invert();
        t_collide();
        t_data();
        conclude();
    end

    // hang guard, about ten thousand cycles
    initial begin
        #1000000;
        error_cnt++;
        conclude();
    end
endmodule
